// file: hdl/wdg_prescaler.sv
/*
 Prescaler that, while run is high, issues one tick every DIV enabled source-clock cycles.
 Assumes the source clock arrives as a one-cycle enable pulse synchronous to clk.
*/
module wdg_prescaler #(
   parameter int DIV = window_watchdog_pkg::PRESCALE_DIV
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic srcTick,
   input wire logic run,
   output logic tick
);
   import window_watchdog_pkg::*;

   localparam int W = $clog2(DIV);

   logic [W-1:0] count_q; // Prescaler position.
   logic [W-1:0] count_d;
   logic tick_q;
   logic tick_d;

   // Next-value logic; never cleared by counter writes.
   always_comb begin
      count_d = count_q;
      tick_d = 1'b0;
      if (run && srcTick) begin
         if (count_q == W'(DIV - 1)) begin
            count_d = '0;
            tick_d = 1'b1;
         end else begin
            count_d = count_q + W'(1);
         end
      end
   end

   // Registers of the prescaler.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
         tick_q <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : wdg_prescaler

// file: hdl/window_watchdog.sv
/*
 Window watchdog core with a classic Wishbone register port and a chip reset request output.
 Assumes the CPU signals halt entry, wake events and low-power state as synchronous one-cycle pulses or levels.
*/
module window_watchdog #(
   parameter int PRESCALE = window_watchdog_pkg::PRESCALE_DIV,
   parameter int PULSE_CYCLES = window_watchdog_pkg::RESET_PULSE_CYCLES,
   parameter int WAKE_SHORT = window_watchdog_pkg::WAKE_DELAY_SHORT,
   parameter int WAKE_LONG = window_watchdog_pkg::WAKE_DELAY_LONG
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic srcTick,
   input wire logic hwWatchdogOption,
   input wire logic haltResetOption,
   input wire logic activeHaltSelect,
   input wire logic longWakeDelay,
   input wire logic haltRequest,
   input wire logic wakeInterrupt,
   output logic haltGranted,
   output logic chipResetReq_n
);
   import window_watchdog_pkg::*;

   typedef enum {RUN, HALTSTEP, HALTED, ACTHALT, WAKEWAIT} mode_e;

   localparam int PW = $clog2(PULSE_CYCLES + 1);
   localparam int WW = $clog2(WAKE_LONG + 1);

   logic [6:0] count_q, count_d; // Downcounter.
   logic [6:0] window_q, window_d; // Window limit.
   logic active_q, active_d; // Activation bit.
   logic [PW-1:0] pulse_q, pulse_d; // Reset pulse timer.
   logic rstOut_n_q, rstOut_n_d; // Registered reset output.
   logic [WW-1:0] wake_q, wake_d; // Wake delay timer.
   logic [31:0] rdat_q, rdat_d; // Read data.
   logic ack_q, ack_d; // Bus acknowledge.
   logic halt_q, halt_d; // Halt granted output.
   logic lastCause_q, lastCause_d; // Last reset was watchdog-caused.
   logic strapPending_q; // Wake delay pending after reset.
   mode_e mode_q, mode_d;
   logic tick; // Prescaler decrement pulse.
   logic countRun; // Counter allowed to move.
   logic busReq; // New bus access in this cycle.
   logic ctrlWrite;
   logic enabled;

   // Decides whether the watchdog may raise a reset.
   function automatic logic isEnabled(input logic hw, input logic act);
      return hw | act;
   endfunction : isEnabled

   assign busReq = wb_cyc_i && wb_stb_i && !ack_q;
   assign ctrlWrite = busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFFSET;
   assign enabled = isEnabled(hwWatchdogOption, active_q);
   assign countRun = (mode_q == RUN) || (mode_q == HALTSTEP);

   wdg_prescaler #(.DIV(PRESCALE)) u_pre (
      .clk(clk),
      .arst_n(arst_n),
      .srcTick(srcTick),
      .run(countRun),
      .tick(tick)
   );

   // Catches the restart delay after each arst_n release.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strapPending_q <= 1'b1;
      end else begin
         strapPending_q <= 1'b0;
      end
   end

   // Counter, window, activation, mode and reset pulse next values.
   always_comb begin
      count_d = count_q;
      window_d = window_q;
      active_d = active_q;
      mode_d = mode_q;
      wake_d = wake_q;
      pulse_d = pulse_q;
      halt_d = 1'b0;
      lastCause_d = lastCause_q;
      if (tick && countRun) begin
         count_d = count_q - 7'h01;
      end
      if (ctrlWrite) begin
         count_d = wb_dat_i[6:0];
         if (wb_dat_i[ACT_BIT]) begin
            active_d = 1'b1;
         end
      end
      if (busReq && wb_we_i && wb_sel_i[0] && wb_adr_i == WINDOW_OFFSET) begin
         window_d = wb_dat_i[6:0];
      end
      // Low-power sequencing.
      case (mode_q)
         RUN: begin
            if (haltRequest) begin
               if (activeHaltSelect) begin
                  mode_d = ACTHALT;
                  halt_d = 1'b1;
               end else if (!(enabled && haltResetOption)) begin
                  mode_d = HALTSTEP;
                  halt_d = 1'b1;
               end
            end
         end
         HALTSTEP: begin
            halt_d = 1'b1;
            if (tick) begin
               mode_d = HALTED;
            end
         end
         HALTED: begin
            halt_d = 1'b1;
            if (wakeInterrupt) begin
               mode_d = WAKEWAIT;
               halt_d = 1'b0;
               wake_d = longWakeDelay ? WW'(WAKE_LONG) : WW'(WAKE_SHORT);
            end
         end
         ACTHALT: begin
            halt_d = 1'b1;
            if (wakeInterrupt) begin
               mode_d = RUN;
               halt_d = 1'b0;
            end
         end
         WAKEWAIT: begin
            if (wake_q <= WW'(1)) begin
               mode_d = RUN;
               wake_d = '0;
            end else begin
               wake_d = wake_q - WW'(1);
            end
         end
         default: begin
            mode_d = RUN;
         end
      endcase
      // Reset pulse generation.
      if (pulse_q != '0) begin
         pulse_d = pulse_q - PW'(1);
      end else begin
         // Expiry, window and halt causes need a running counter.
         if (enabled && countRun) begin
            if (tick && count_q == (EXPIRE_VALUE + 7'h01) && !(ctrlWrite)) begin
               pulse_d = PW'(PULSE_CYCLES);
            end
            if (ctrlWrite && count_q > window_q) begin
               pulse_d = PW'(PULSE_CYCLES);
            end
            if (mode_q == RUN && haltRequest && !activeHaltSelect && haltResetOption) begin
               pulse_d = PW'(PULSE_CYCLES);
            end
         end
         // software reset
         // A cleared top bit while enabled or activating resets even during a wake delay.
         if (ctrlWrite && (enabled || wb_dat_i[ACT_BIT]) && !wb_dat_i[TOP_BIT]) begin
            pulse_d = PW'(PULSE_CYCLES);
         end
      end
      if (pulse_d != '0 && pulse_q == '0) begin
         lastCause_d = 1'b1;
      end
      rstOut_n_d = (pulse_d == '0);
      if (pulse_q == PW'(1)) begin
         count_d = COUNT_RESET;
         window_d = WINDOW_RESET;
         active_d = 1'b0;
         wake_d = longWakeDelay ? WW'(WAKE_LONG) : WW'(WAKE_SHORT);
         mode_d = WAKEWAIT;
         halt_d = 1'b0;
      end
      if (strapPending_q) begin
         wake_d = longWakeDelay ? WW'(WAKE_LONG) : WW'(WAKE_SHORT);
         mode_d = WAKEWAIT;
      end
   end

   // Bus answer: one cycle after the request, dropped the cycle after.
   always_comb begin
      ack_d = busReq;
      rdat_d = rdat_q;
      if (busReq && !wb_we_i) begin
         case (wb_adr_i)
            CTRL_OFFSET: rdat_d = {24'h000000, active_q, count_q};
            WINDOW_OFFSET: rdat_d = {24'h000000, 1'b0, window_q};
            STATUS_OFFSET: rdat_d = {29'h00000000, lastCause_q, halt_q, enabled};
            default: rdat_d = 32'h00000000;
         endcase
      end
   end

   // State registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= COUNT_RESET;
         window_q <= WINDOW_RESET;
         active_q <= 1'b0;
         mode_q <= RUN;
         wake_q <= '0;
         pulse_q <= '0;
         rstOut_n_q <= 1'b1;
         halt_q <= 1'b0;
         lastCause_q <= 1'b0;
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         count_q <= count_d;
         window_q <= window_d;
         active_q <= active_d;
         mode_q <= mode_d;
         wake_q <= wake_d;
         pulse_q <= pulse_d;
         rstOut_n_q <= rstOut_n_d;
         halt_q <= halt_d;
         lastCause_q <= lastCause_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign haltGranted = halt_q;
   assign chipResetReq_n = rstOut_n_q;
endmodule : window_watchdog

// file: pkg/window_watchdog_pkg.sv
/*
 Constants for the window watchdog: register offsets, field positions, reset values and timing counts.
 Assumes a 100 MHz system clock and a 32-bit classic Wishbone register port with word-aligned registers.
*/
// Functional notes
// - Decrement counter every 16384 source-clock cycles.
// - Low six bits give remaining decrement steps.
// - Top bit clearing while active starts reset.
// - Refresh above window limit causes reset.
// - Software activation sticks until device reset.
// - Hardware option keeps watchdog always active.
// - Counter free-runs even when not activated.
// - Activate with top bit zero forces reset.
// - Counter write leaves prescaler untouched.
// - Halt with halt-reset option resets device.
// - Slow and wait modes keep normal counting.
// - Plain halt: one decrement, then counting stops.
// - Interrupt wake resumes after 256/4096 clocks.
// - Reset ending halt restores disabled state.
// - Active halt freezes counter; restart rules.
// - Activation bit set by software, reset-cleared.
// - Window limit is seven bits, compared.
package window_watchdog_pkg;
   // Byte offsets of the registers on the bus.
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] WINDOW_OFFSET = 4'h4;
   localparam logic [3:0] STATUS_OFFSET = 4'h8;
   // Field positions in the control register.
   localparam int ACT_BIT = 7;
   localparam int TOP_BIT = 6;
   // Reset values of control counter and window limit.
   localparam logic [6:0] COUNT_RESET = 7'h7F;
   localparam logic [6:0] WINDOW_RESET = 7'h7F;
   // Value the counter reaches when the top bit clears.
   localparam logic [6:0] EXPIRE_VALUE = 7'h3F;
   // Prescaler division of the source clock.
   localparam int PRESCALE_DIV = 16384;
   // Reset pulse length and its cycle count at 100 MHz.
   localparam int RESET_PULSE_NS = 30000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;
   // Restart delays after waking from halt, in CPU clocks.
   localparam int WAKE_DELAY_SHORT = 256;
   localparam int WAKE_DELAY_LONG = 4096;
endpackage : window_watchdog_pkg

// file: verification/wdg_source_model.sv
/*
 Far side of the watchdog: source clock enable and the chip reset circuitry.
 Assumes the bench chooses normal or slow source rate.
*/
module wdg_source_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slowSrc,
   input wire logic chipResetReq_n,
   output logic srcTick,
   output int pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   // Phase of the halved source clock.
   logic phase_q;
   // Toggles every cycle for slow mode.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) phase_q <= 1'b0;
      else phase_q <= !phase_q;
   end
   assign srcTick = !slowSrc || phase_q;
   // Counts the reset pulses that reach the chip.
   initial pulses = 0;
   always @(negedge chipResetReq_n) begin
      pulses <= pulses + 1;
   end
endmodule : wdg_source_model

// file: verification/window_watchdog_properties.sv
/*
 Port checker for the window watchdog: bus handshake, reset pulse and halt.
 Assumes it is bound to the top module and sees only its ports.
*/
module window_watchdog_properties #(
   parameter int PULSE_CYCLES = 5
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic srcTick,
   input wire logic hwWatchdogOption,
   input wire logic haltResetOption,
   input wire logic activeHaltSelect,
   input wire logic longWakeDelay,
   input wire logic haltRequest,
   input wire logic wakeInterrupt,
   input wire logic haltGranted,
   input wire logic chipResetReq_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Low-cycle count of the reset request, and its next value.
   int lowCnt_d;
   int lowCnt_q;
   // A bus request taken at this edge.
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Next count: restarts whenever the request is high.
   always_comb begin
      lowCnt_d = chipResetReq_n ? 0 : lowCnt_q + 1;
   end
   // Registers the low-cycle count.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) lowCnt_q <= 0;
      else lowCnt_q <= lowCnt_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_ack_answer: assert property (take |=> wb_ack_o) else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack idle");
   a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
   a_read_hole: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'hC |-> wb_dat_o == 32'h0)
      else $error("hole read");
   a_soft_reset: assert property (take && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0] && wb_dat_i[7:6] == 2'b10
      && chipResetReq_n |-> ##2 !chipResetReq_n) else $error("soft reset");
   a_halt_reset: assert property (haltRequest && haltResetOption && hwWatchdogOption && !activeHaltSelect
      && chipResetReq_n |-> ##2 !chipResetReq_n) else $error("halt reset");
   a_halt_enter: assert property (haltRequest && (activeHaltSelect || !haltResetOption)
      && chipResetReq_n |-> ##[1:2] haltGranted) else $error("no halt");
   a_pulse_len: assert property ($rose(chipResetReq_n) |-> lowCnt_q == PULSE_CYCLES) else $error("pulse");
   cover property ($rose(haltGranted));
   cover property ($rose(chipResetReq_n));
   cover property (take && wb_we_i && wb_dat_i[7:6] == 2'b10);
endmodule : window_watchdog_properties

// file: verification/window_watchdog_tb.sv
/*
 Self-checking bench for the window watchdog with short counts.
 Assumes the source model and the port checker are compiled before it.
*/
module window_watchdog_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, cyc, stb, we, ack, srcTick, hwOpt, haltOpt, ahs, longWake;
   logic haltReq, wake, haltGranted, rstN, slowSrc;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat;
   int errors, totalChecks, rstQ, pulses;
   logic [31:0] rdQ[$];
   window_watchdog #(.PRESCALE(4), .PULSE_CYCLES(5), .WAKE_SHORT(4), .WAKE_LONG(8)) dut_u (
      .clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .srcTick(srcTick),
      .hwWatchdogOption(hwOpt), .haltResetOption(haltOpt), .activeHaltSelect(ahs),
      .longWakeDelay(longWake), .haltRequest(haltReq), .wakeInterrupt(wake),
      .haltGranted(haltGranted), .chipResetReq_n(rstN));
   wdg_source_model src_u (.clk(clk), .arst_n(arst_n), .slowSrc(slowSrc), .chipResetReq_n(rstN),
      .srcTick(srcTick), .pulses(pulses));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts and reports one comparison.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // One classic bus cycle, held until ack.
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) errors++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   // Read with its expected word noted first.
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      wb(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   // Waits for an already noted reset pulse to start and to end.
   task automatic expectReset;
      int n;
      n = 0;
      while (rstN !== 1'b0 && n < 900) begin
         @(posedge clk);
         n++;
      end
      while (rstN !== 1'b1 && n < 900) begin
         @(posedge clk);
         n++;
      end
      if (n >= 900) errors++;
      repeat (12) @(posedge clk);
   endtask : expectReset
   // Prints the counts and the verdict.
   task automatic complete_run;
      chk("pending", 32'h0, 32'(rdQ.size() + rstQ));
      $display("checks %0d errors %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   // Takes the oldest note whenever a result appears.
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) chk("rdata", rdQ.pop_front(), rdat);
      if ($fell(rstN)) begin
         chk("reset", 32'h1, 32'(rstQ > 0));
         rstQ--;
      end
   end
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end
   initial begin
      logic [6:0] w;
      int i;
      {cyc, stb, we, haltReq, wake, hwOpt, haltOpt, ahs, slowSrc, arst_n} = '0;
      {adr, sel, wdat} = '0;
      longWake = 1'b1;
      {errors, totalChecks, rstQ} = '0;
      void'($urandom(32'h2889));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      rd(4'h0, 32'h7F);
      rd(4'h4, 32'h7F);
      rd(4'h8, 32'h0);
      rd(4'hC, 32'h0);
      wb(1'b1, 4'h0, 32'h80, 4'hE);
      wb(1'b1, 4'hC, 32'h80, 4'hF);
      w = 7'h41 + 7'($urandom % 47);
      wb(1'b1, 4'h4, {24'h0, 1'b1, w}, 4'hF);
      rd(4'h4, {25'h0, w});
      wb(1'b1, 4'h0, 32'hFF, 4'hF);
      rd(4'h8, 32'h1);
      // The reset is noted before its cause, so the monitor never sees it early.
      rstQ++;
      wb(1'b1, 4'h0, 32'hFF, 4'hF);
      expectReset();
      rd(4'h8, 32'h4);
      repeat (300) @(posedge clk);
      rstQ++;
      wb(1'b1, 4'h0, 32'h80, 4'hF);
      expectReset();
      slowSrc <= 1'b1;
      wb(1'b1, 4'h0, 32'hFF, 4'hF);
      rstQ++;
      wb(1'b1, 4'h0, {24'h0, 2'b01, 6'($urandom % 64)}, 4'hF);
      rd(4'h8, 32'h5);
      expectReset();
      slowSrc <= 1'b0;
      hwOpt <= 1'b1;
      for (i = 1; i >= 0; i--) begin
         ahs <= i[0];
         longWake <= i[0];
         wb(1'b1, 4'h0, 32'hC2, 4'hF);
         haltReq <= 1'b1;
         @(posedge clk);
         haltReq <= 1'b0;
         repeat (100) @(posedge clk);
         chk("halted", 32'h1, 32'(haltGranted));
         rstQ++;
         wake <= 1'b1;
         @(posedge clk);
         wake <= 1'b0;
         expectReset();
      end
      ahs <= 1'b0;
      haltOpt <= 1'b1;
      rstQ++;
      @(posedge clk);
      haltReq <= 1'b1;
      @(posedge clk);
      haltReq <= 1'b0;
      expectReset();
      hwOpt <= 1'b0;
      chk("pulses", 32'h6, 32'(pulses));
      complete_run();
   end
endmodule : window_watchdog_tb
bind window_watchdog window_watchdog_properties #(.PULSE_CYCLES(PULSE_CYCLES)) props_u (
   .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .srcTick(srcTick), .hwWatchdogOption(hwWatchdogOption),
   .haltResetOption(haltResetOption), .activeHaltSelect(activeHaltSelect),
   .longWakeDelay(longWakeDelay), .haltRequest(haltRequest), .wakeInterrupt(wakeInterrupt),
   .haltGranted(haltGranted), .chipResetReq_n(chipResetReq_n));
